// >>> verilog/tad_top.v
// Trip annunciator display: readout, pointer indicators, Avalon registers
`timescale 1ns/1ps
`include "tad_regs.vh"

module tad_top #(
  parameter CUR_W = 16
) (
  input wire core_clk,
  input wire reset,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [1:0] avs_response,
  input wire step_button,
  input wire reset_button,
  input wire test_button,
  input wire [2:0] test_select,
  input wire trip_event,
  input wire [2:0] trip_cause,
  input wire over_range,
  input wire overload_pending,
  input wire plug_fault,
  input wire data_mem_fail,
  input wire prog_mem_fail,
  input wire [CUR_W-1:0] phase_a_current,
  input wire [CUR_W-1:0] phase_b_current,
  input wire [CUR_W-1:0] phase_c_current,
  input wire [CUR_W-1:0] ground_current,
  output reg [31:0] readout_text,
  output reg readout_numeric,
  output reg [CUR_W-1:0] readout_value,
  output reg [3:0] pointer_led,
  output reg [6:0] cause_led,
  output reg selftest_rerun
);

  // Button pins: three-stage synchronisers; a level counts once stages 2
  // and 3 agree, so a one-cycle glitch never turns into a press
  localparam NBTN = 3;
  localparam BTN_STEP = 0;
  localparam BTN_RST = 1;
  localparam BTN_TEST = 2;
  wire [NBTN-1:0] btn_pin;
  wire [NBTN-1:0] btn_press;
  wire [NBTN-1:0] btn_lvl;
  wire step_press;
  wire rst_press;
  wire test_held;

  assign btn_pin = {test_button, reset_button, step_button};
  assign step_press = btn_press[BTN_STEP];
  assign rst_press = btn_press[BTN_RST];
  assign test_held = btn_lvl[BTN_TEST];

  genvar g;
  generate
    for (g = 0; g < NBTN; g = g + 1)
    begin : g_btn
      reg [2:0] sync_q;
      reg lvl_q;
      wire agree = (sync_q[1] == sync_q[2]);
      // A press is the rising edge of the filtered level
      assign btn_press[g] = agree & sync_q[2] & ~lvl_q;
      assign btn_lvl[g] = lvl_q;
      always @(posedge core_clk or posedge reset)
      begin
        if (reset)
        begin
          sync_q <= 3'h0;
          lvl_q <= 1'b0;
        end
        else
        begin
          sync_q <= {sync_q[1:0], btn_pin[g]};
          if (agree)
            lvl_q <= sync_q[2];
        end
      end
    end
  endgenerate

  // Blank text for no cause keeps a stray code off the readout
  function [31:0] cause_text;
    input [2:0] c;
    begin
      case (c)
        `TAD_CAUSE_FAST: cause_text = `TAD_TXT_FAST;
        `TAD_CAUSE_SHORT: cause_text = `TAD_TXT_SHORT;
        `TAD_CAUSE_LONG: cause_text = `TAD_TXT_LONG;
        `TAD_CAUSE_EARTH: cause_text = `TAD_TXT_EARTH;
        `TAD_CAUSE_MAKING: cause_text = `TAD_TXT_MAKING;
        `TAD_CAUSE_OVERRIDE: cause_text = `TAD_TXT_OVERRIDE;
        default: cause_text = 32'h20202020;
      endcase
    end
  endfunction

  reg [31:0] ctrl_q;
  wire gf_en = ctrl_q[`TAD_CTRL_GF_EN];
  reg [1:0] mode_q;
  reg [1:0] sel_q;
  reg [2:0] cause_q;
  reg over_range_code_q;
  reg [CUR_W-1:0] cap_q [0:3];
  reg [CUR_W-1:0] live_q [0:3];
  reg [3:0] rerun_cnt_q;
  wire [1:0] last_sel = gf_en ? 2'h3 : 2'h2;
  wire sel_wrap = (sel_q >= last_sel);
  integer i;

  // Live samples run one cycle behind, so the capture is the pre-trip value
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      for (i = 0; i < 4; i = i + 1)
        live_q[i] <= {CUR_W{1'b0}};
    end
    else
    begin
      live_q[0] <= phase_a_current;
      live_q[1] <= phase_b_current;
      live_q[2] <= phase_c_current;
      // Without the ground option the channel reads zero, never stale data
      if (gf_en)
        live_q[3] <= ground_current;
      else
        live_q[3] <= {CUR_W{1'b0}};
    end
  end

  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      mode_q <= `TAD_MODE_METER;
      sel_q <= 2'h0;
      cause_q <= `TAD_CAUSE_NONE;
      over_range_code_q <= 1'b0;
      rerun_cnt_q <= 4'h0;
      for (i = 0; i < 4; i = i + 1)
        cap_q[i] <= {CUR_W{1'b0}};
    end
    else
    begin
      if (rerun_cnt_q != 4'h0)
        rerun_cnt_q <= rerun_cnt_q - 4'h1;
      if (!gf_en && sel_q == 2'h3)
        sel_q <= 2'h0;
      // A new trip wins over a reset press in the same cycle
      // Trips are taken only in meter mode, so a record is never overwritten
      if (trip_event && mode_q == `TAD_MODE_METER)
      begin
        mode_q <= `TAD_MODE_CAUSE;
        cause_q <= trip_cause;
        over_range_code_q <= over_range;
        sel_q <= 2'h0;
        for (i = 0; i < 4; i = i + 1)
          cap_q[i] <= live_q[i];
      end
      else if (rst_press)
      begin
        mode_q <= `TAD_MODE_METER;
        cause_q <= `TAD_CAUSE_NONE;
        over_range_code_q <= 1'b0;
        sel_q <= 2'h0;
        rerun_cnt_q <= `TAD_SELFTEST_CYC;
      end
      else if (step_press)
      begin
        if (mode_q == `TAD_MODE_CAUSE)
          mode_q <= `TAD_MODE_CAPTURE;
        else
        begin
          if (sel_wrap)
            sel_q <= 2'h0;
          else
            sel_q <= sel_q + 2'h1;
        end
      end
    end
  end

  // Fault and test messages pre-empt everything else on the readout
  reg [31:0] txt_d;
  reg num_d;
  reg [CUR_W-1:0] val_d;
  wire test_ok = (test_select == `TAD_TEST_FULL_PHASE) ||
                 (test_select == `TAD_TEST_EARTH);

  always @*
  begin
    txt_d = 32'h20202020;
    num_d = 1'b0;
    val_d = {CUR_W{1'b0}};
    if (prog_mem_fail)
      txt_d = `TAD_TXT_PROG_MEM;
    else if (data_mem_fail)
      txt_d = `TAD_TXT_DATA_MEM;
    else if (plug_fault)
      txt_d = `TAD_TXT_PLUG;
    else if (test_held && test_ok)
      txt_d = `TAD_TXT_TEST;
    else if (mode_q == `TAD_MODE_CAUSE)
      txt_d = cause_text(cause_q);
    else if (mode_q == `TAD_MODE_CAPTURE)
    begin
      if (cause_q == `TAD_CAUSE_OVERRIDE && over_range_code_q)
        txt_d = `TAD_TXT_OVRANGE;
      else
      begin
        num_d = 1'b1;
        val_d = cap_q[sel_q];
      end
    end
    else if (overload_pending)
      txt_d = `TAD_TXT_PENDING;
    // Meter shows the live value of the pointed channel
    else
    begin
      num_d = 1'b1;
      val_d = live_q[sel_q];
    end
  end

  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      readout_text <= 32'h20202020;
      readout_numeric <= 1'b0;
      readout_value <= {CUR_W{1'b0}};
      pointer_led <= 4'h0;
      cause_led <= 7'h00;
      selftest_rerun <= 1'b0;
    end
    else
    begin
      readout_text <= txt_d;
      readout_numeric <= num_d;
      readout_value <= val_d;
      pointer_led <= 4'h1 << sel_q;
      // Trip lamps stay lit until a reset press, as long as power lasts
      if (mode_q == `TAD_MODE_METER)
        cause_led <= 7'h00;
      else
        cause_led <= 7'h01 << cause_q;
      // The pulse tells the memory checks to start over
      selftest_rerun <= (rerun_cnt_q != 4'h0);
    end
  end

  // Avalon slave: one wait cycle, then answer; unmapped reads zero, SLVERR
  // Only the ground option bit of ctrl is writable
  reg ack_q;
  wire req = (avs_read | avs_write) & ~ack_q;
  reg [31:0] rd_d;
  reg hit_d;

  always @*
  begin
    rd_d = 32'h00000000;
    hit_d = 1'b1;
    case (avs_address)
      `TAD_REG_CTRL: rd_d = ctrl_q;
      // Status packs selection, mode, cause and over-range for software
      `TAD_REG_STATUS: rd_d = {19'h0, over_range_code_q, 1'b0, cause_q, 2'h0,
                               mode_q, 2'h0, sel_q};
      `TAD_REG_DISPLAY: rd_d = readout_text;
      `TAD_REG_CUR_A: rd_d = {{(32-CUR_W){1'b0}}, cap_q[0]};
      `TAD_REG_CUR_B: rd_d = {{(32-CUR_W){1'b0}}, cap_q[1]};
      `TAD_REG_CUR_C: rd_d = {{(32-CUR_W){1'b0}}, cap_q[2]};
      `TAD_REG_CUR_G: rd_d = {{(32-CUR_W){1'b0}}, cap_q[3]};
      default: hit_d = 1'b0;
    endcase
  end

  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      ack_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      avs_response <= 2'h0;
      ctrl_q <= `TAD_CTRL_RESET_VAL;
    end
    else
    begin
      ack_q <= req;
      avs_waitrequest <= ~req;
      if (req)
      begin
        if (avs_read)
          avs_readdata <= rd_d;
        else
          avs_readdata <= 32'h00000000;
        if (hit_d)
          avs_response <= 2'h0;
        else
          avs_response <= 2'h2;
      end
      // Writes land on the answer edge, where the master sees waitrequest low
      if (avs_write && !avs_waitrequest)
      begin
        case (avs_address)
          `TAD_REG_CTRL:
          begin
            if (avs_byteenable[0])
              ctrl_q[0] <= avs_writedata[0];
          end
          default:
            ctrl_q <= ctrl_q;
        endcase
      end
    end
  end

endmodule

// >>> shared/tad_regs.vh
// Constants for the trip annunciator display block
`ifndef TAD_REGS_VH
`define TAD_REGS_VH
// Avalon register byte offsets
`define TAD_REG_CTRL 8'h00
`define TAD_REG_STATUS 8'h04
`define TAD_REG_DISPLAY 8'h08
`define TAD_REG_CUR_A 8'h0c
`define TAD_REG_CUR_B 8'h10
`define TAD_REG_CUR_C 8'h14
`define TAD_REG_CUR_G 8'h18
// Control register bits
`define TAD_CTRL_GF_EN 0
`define TAD_CTRL_RESET_VAL 32'h00000000
// Status register fields
`define TAD_ST_SEL_LSB 0
`define TAD_ST_MODE_LSB 4
`define TAD_ST_CAUSE_LSB 8
`define TAD_ST_OVER_RANGE_CODE 12
// Trip cause encodings
`define TAD_CAUSE_NONE 3'h0
`define TAD_CAUSE_FAST 3'h1
`define TAD_CAUSE_SHORT 3'h2
`define TAD_CAUSE_LONG 3'h3
`define TAD_CAUSE_EARTH 3'h4
`define TAD_CAUSE_MAKING 3'h5
`define TAD_CAUSE_OVERRIDE 3'h6
// Test selection encodings
`define TAD_TEST_FULL_PHASE 3'h5
`define TAD_TEST_EARTH 3'h6
// Four-character codes, ASCII
`define TAD_TXT_FAST 32'h46535454
`define TAD_TXT_SHORT 32'h53445420
`define TAD_TXT_LONG 32'h4c445420
`define TAD_TXT_EARTH 32'h45415254
`define TAD_TXT_MAKING 32'h4d414b45
`define TAD_TXT_OVERRIDE 32'h4f565244
`define TAD_TXT_OVRANGE 32'h4f565247
`define TAD_TXT_PENDING 32'h4f4c5044
`define TAD_TXT_TEST 32'h54455354
`define TAD_TXT_PLUG 32'h504c5547
`define TAD_TXT_DATA_MEM 32'h444d454d
`define TAD_TXT_PROG_MEM 32'h504d454d
// Display modes
`define TAD_MODE_METER 2'h0
`define TAD_MODE_CAUSE 2'h1
`define TAD_MODE_CAPTURE 2'h2
// Self-test restart pulse width, cycles
`define TAD_SELFTEST_CYC 4'h4
`endif

// >>> testbench/tad_top_properties.sv
// Port checker for the trip annunciator display
`timescale 1ns/1ps
`include "tad_regs.vh"
module tad_chk (
  input wire core_clk,
  input wire reset,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [1:0] avs_response,
  input wire step_button,
  input wire reset_button,
  input wire test_button,
  input wire [2:0] test_select,
  input wire trip_event,
  input wire plug_fault,
  input wire data_mem_fail,
  input wire prog_mem_fail,
  input wire [31:0] readout_text,
  input wire [3:0] pointer_led,
  input wire [6:0] cause_led,
  input wire selftest_rerun
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Eight idle cycles outlast the button filter and output register
  sequence quiet_s;
    (!step_button && !reset_button && !trip_event && !avs_write)[*8];
  endsequence
  sequence test_s;
    (test_button && test_select[2] && (test_select[1] ^ test_select[0])
      && !plug_fault && !data_mem_fail && !prog_mem_fail)[*8];
  endsequence
  sequence plug_s;
    (plug_fault && !data_mem_fail && !prog_mem_fail)[*6];
  endsequence
  chk_one_pointer: assert property (
    !$past(reset) |-> $onehot(pointer_led))
    else $error("pointer not one-hot");
  chk_cause_onehot: assert property ($onehot0(cause_led))
    else $error("more than one cause lamp");
  chk_view_held: assert property (quiet_s |->
    $stable(cause_led) && $stable(pointer_led))
    else $error("display moved without a press");
  chk_test_code: assert property (test_s |->
    readout_text == `TAD_TXT_TEST) else $error("test code missing");
  chk_plug_code: assert property (plug_s |->
    readout_text == `TAD_TXT_PLUG) else $error("plug code missing");
  chk_rerun_width: assert property ($rose(selftest_rerun) |->
    selftest_rerun[*4] ##1 !selftest_rerun) else $error("rerun width");
  chk_wait_answer: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest) else $error("no bus answer");
  chk_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  chk_unmapped_read: assert property (avs_read && !avs_waitrequest &&
    avs_address > 8'h18 |-> avs_response == 2'h2 && avs_readdata == 32'h0)
    else $error("unmapped read answer");
endmodule
bind tad_top tad_chk u_chk (.core_clk, .reset, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .avs_response, .step_button,
  .reset_button, .test_button, .test_select, .trip_event, .plug_fault,
  .data_mem_fail, .prog_mem_fail, .readout_text, .pointer_led, .cause_led,
  .selftest_rerun);

// >>> testbench/tad_prot_model.sv
// Protection logic stand-in that reports trips on request
`timescale 1ns/1ps
module tad_prot_model (
  input wire core_clk,
  input wire fire,
  input wire [2:0] cause_in,
  input wire range_in,
  output reg trip_event,
  output reg [2:0] trip_cause,
  output reg over_range
);
  initial
  begin
    trip_event = 1'b0;
    trip_cause = 3'h0;
    over_range = 1'b0;
  end
  // Cause and range only mean something with the event, so churn them
  always @(posedge core_clk)
  begin
    trip_event <= fire;
    trip_cause <= fire ? cause_in : ~trip_cause;
    over_range <= fire ? range_in : ~over_range;
  end
endmodule

// >>> testbench/test_trip_annunciator_display.sv
// Self-checking bench for the trip annunciator display
`timescale 1ns/1ps
`include "tad_regs.vh"
module test_trip_annunciator_display;
  reg core_clk = 1'b0;
  reg reset = 1'b1;
  reg [7:0] adr = 8'h00;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wdat = 32'h0;
  reg [2:0] btn = 3'h0;
  reg [2:0] tsel = 3'h0;
  reg [2:0] fault = 3'h0;
  reg pend = 1'b0;
  reg fire = 1'b0;
  reg [2:0] cause = 3'h0;
  reg range = 1'b0;
  reg [15:0] cur [0:3];
  reg [15:0] cap [0:3];
  reg [31:0] q;
  reg [1:0] r;
  wire [31:0] rdat;
  wire wait_req;
  wire [1:0] resp;
  wire tev;
  wire [2:0] tcause;
  wire over_range_code;
  wire [31:0] text;
  wire num;
  wire [15:0] val;
  wire [3:0] ptr;
  wire [6:0] lamp;
  integer mismatches = 0;
  integer checks_done = 0;
  integer i;
  integer c;
  integer n;
  always #10 core_clk = ~core_clk;
  tad_prot_model i_tad_prot_model (.core_clk(core_clk), .fire(fire),
    .cause_in(cause), .range_in(range), .trip_event(tev),
    .trip_cause(tcause), .over_range(over_range_code));
  tad_top i_tad_top (.core_clk(core_clk), .reset(reset), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wait_req),
    .avs_response(resp), .step_button(btn[0]), .reset_button(btn[1]),
    .test_button(btn[2]), .test_select(tsel), .trip_event(tev),
    .trip_cause(tcause), .over_range(over_range_code), .overload_pending(pend),
    .plug_fault(fault[0]), .data_mem_fail(fault[1]),
    .prog_mem_fail(fault[2]), .phase_a_current(cur[0]),
    .phase_b_current(cur[1]), .phase_c_current(cur[2]),
    .ground_current(cur[3]), .readout_text(text), .readout_numeric(num),
    .readout_value(val), .pointer_led(ptr), .cause_led(lamp),
    .selftest_rerun());
  function [31:0] txt(input [3:0] k);
    case (k)
      4'h1: txt = `TAD_TXT_FAST;
      4'h2: txt = `TAD_TXT_SHORT;
      4'h3: txt = `TAD_TXT_LONG;
      4'h4: txt = `TAD_TXT_EARTH;
      4'h5: txt = `TAD_TXT_MAKING;
      4'h6: txt = `TAD_TXT_OVERRIDE;
      4'h8: txt = `TAD_TXT_PLUG;
      4'h9: txt = `TAD_TXT_DATA_MEM;
      default: txt = `TAD_TXT_PROG_MEM;
    endcase
  endfunction
  function [15:0] rnd16;
    input dummy;
    reg [31:0] t;
  begin
    t = $urandom;
    rnd16 = t[15:0];
  end
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task bus(input we, input [7:0] a, input [31:0] d);
  begin
    @(posedge core_clk);
    adr <= a;
    wr <= we;
    rd <= !we;
    wdat <= d;
    @(posedge core_clk);
    // Only the watchdog ends a wait that never gets its answer
    while (wait_req !== 1'b0)
      @(posedge core_clk);
    q = rdat;
    r = resp;
    rd <= 1'b0;
    wr <= 1'b0;
  end
  endtask
  task press(input integer b);
  begin
    btn[b] <= 1'b1;
    repeat (8) @(posedge core_clk);
    btn[b] <= 1'b0;
    repeat (8) @(posedge core_clk);
  end
  endtask
  task give_verdict;
  begin
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches = mismatches + 1;
    give_verdict;
  end
  initial
  begin
    for (i = 0; i < 4; i = i + 1)
      cur[i] = 16'h0;
    q = $urandom(32'hc7e686ce);
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(ptr, 4'h1);
    chk(lamp, 7'h0);
    bus(1'b0, `TAD_REG_CTRL, 32'h0);
    chk(q, `TAD_CTRL_RESET_VAL);
    bus(1'b0, 8'h40, 32'h0);
    chk(r, 2'h2);
    for (i = 0; i < 4; i = i + 1)
      cur[i] <= rnd16(1'b0);
    for (c = 1; c >= 0; c = c - 1)
    begin
      bus(1'b1, `TAD_REG_CTRL, c);
      n = 3 + c;
      for (i = 0; i <= n; i = i + 1)
      begin
        repeat (2) @(posedge core_clk);
        chk(ptr, 4'h1 << (i % n));
        chk({num, val}, {1'b1, cur[i % n]});
        if (i < n)
          press(0);
      end
    end
    for (c = 1; c < 7; c = c + 1)
    begin
      for (i = 0; i < 4; i = i + 1)
        cur[i] <= rnd16(1'b0);
      repeat (3) @(posedge core_clk);
      for (i = 0; i < 4; i = i + 1)
        cap[i] = cur[i];
      fire <= 1'b1;
      cause <= c[2:0];
      range <= (c == 6);
      @(posedge core_clk);
      fire <= 1'b0;
      repeat (2) @(posedge core_clk);
      for (i = 0; i < 4; i = i + 1)
        cur[i] <= rnd16(1'b0);
      repeat (4) @(posedge core_clk);
      chk(text, txt(c));
      chk(lamp, 7'h1 << c);
      for (i = 0; i < 3; i = i + 1)
      begin
        press(0);
        chk(ptr, 4'h1 << i);
        if (c == 6)
          chk(text, `TAD_TXT_OVRANGE);
        else
          chk(val, cap[i]);
      end
      bus(1'b0, `TAD_REG_CUR_A, 32'h0);
      chk(q, cap[0]);
      press(1);
      chk({lamp, num}, 8'h01);
    end
    pend <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk(text, `TAD_TXT_PENDING);
    pend <= 1'b0;
    for (i = 3; i < 7; i = i + 1)
    begin
      tsel <= i[2:0];
      btn[2] <= 1'b1;
      repeat (10) @(posedge core_clk);
      chk(text == `TAD_TXT_TEST, i > 4);
      btn[2] <= 1'b0;
      repeat (10) @(posedge core_clk);
      chk(text == `TAD_TXT_TEST, 1'b0);
    end
    for (i = 0; i < 3; i = i + 1)
    begin
      fault <= 3'h1 << i;
      repeat (8) @(posedge core_clk);
      chk(text, txt(8 + i));
      press(1);
      chk(text, txt(8 + i));
      fault <= 3'h0;
      repeat (8) @(posedge core_clk);
    end
    give_verdict;
  end
endmodule
